/* File: rtl/mmc_cfg.svh */
`ifndef MMC_CFG_SVH
`define MMC_CFG_SVH

// Register offsets.
`define MMC_ADR_BURST 7'h05
`define MMC_ADR_SEQ   7'h06
`define MMC_ADR_MASK  7'h07
`define MMC_ADR_EDGE  7'h09
`define MMC_ADR_KEY   7'h0b

// Software reset key values.
`define MMC_KEY_ARM  8'ha3
`define MMC_KEY_FIRE 8'h05

// Field positions and reset values.
`define MMC_EN_BIT    0
`define MMC_BURST_RST 1'h0
`define MMC_SEQ_RST   1'h0
`define MMC_MASK_RST  8'hff
`define MMC_EDGE_RST  1'h0

// Serial word timing in serial clocks.
`define MMC_WORD_LAST 4'hf
`define MMC_RDATA_BIT 4'h8

`endif

/* File: rtl/mmc_pkg.sv */
package mmc_pkg;

	typedef struct packed {
		logic       rd;
		logic [6:0] adr;
		logic [7:0] dat;
	} mmc_cmd_type;

	typedef struct packed {
		bit        tog;
		bit [15:0] cmd;
	} mmc_word_type;

	typedef struct packed {
		logic [2:0]  bsync;
		logic        bst;
		logic [3:0]  cnt;
		logic        done;
		logic        over;
		logic        mid;
		logic [14:0] sh;
	} mmc_lnk_type;

	typedef struct packed {
		logic [2:0] trg_s;
		logic       trg_st;
		logic [2:0] tog_s;
		logic       tog_st;
		logic [2:0] cs_s;
		logic       cs_st;
		logic [2:0] mid_s;
		logic       mid_st;
		logic [1:0] mid_d;
		logic       burst;
		logic       seq;
		logic [7:0] mask;
		logic       edge_rise;
		logic       armed;
		logic [2:0] chan;
		logic [7:0] rd;
		logic       ferr;
	} mmc_sys_type;

endpackage

/* File: rtl/mmc_regs.sv */
`timescale 1ns/10ps
`include "mmc_cfg.svh"

module mmc_regs #(
	parameter int NCH = 8
) (
	// System clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// Serial link.
	input  wire logic       sclk_i,
	input  wire logic       cs_b_i,
	input  wire logic       sdi_i,
	output logic            sdo_o,
	// Conversion trigger.
	input  wire logic       sequence_trigger_pin_i,
	// Mode and status.
	output logic [2:0]      chan_sel_o,
	output logic            burst_en_o,
	output logic            seq_en_o,
	output logic            frame_err_o
);
	import mmc_pkg::*;

	localparam logic [7:0] MASK_ALL = 8'((1 << NCH) - 1);
	localparam logic [7:0] MASK_RST = `MMC_MASK_RST & MASK_ALL;

	if (NCH != 8 && NCH != 4) begin : g_bad_nch
		$error("NCH must be 8 or 4");
	end

	mmc_sys_type  s_r;
	mmc_sys_type  s_nxt;
	mmc_lnk_type  l_r;
	mmc_lnk_type  l_nxt;
	mmc_word_type w_r;
	mmc_word_type w_nxt;
	logic         sdo_r;
	logic         trg_ev;
	logic         adv;
	logic         cmd_ev;
	logic         cs_rise;
	logic         wr;
	logic         key_fire;
	logic [2:0]   chan_nx;
	mmc_cmd_type  c;

	// Next included channel above the current one, wrapping; holds if none.
	function automatic logic [2:0] next_chan(input logic [2:0] cur, input logic [7:0] m);
		logic [2:0] n;
		n = cur;
		for (int i = NCH; i >= 1; i--) begin
			if (m[(int'(cur) + i) % NCH]) begin
				n = 3'((int'(cur) + i) % NCH);
			end
		end
		return n;
	endfunction

	// Link side: shift serial words on the serial clock, cleared by chip select.
	always_comb begin
		l_nxt = l_r;
		w_nxt = w_r;
		l_nxt.bsync = {l_r.bsync[1:0], s_r.burst};
		if (l_r.bsync[1] == l_r.bsync[2]) begin
			l_nxt.bst = l_r.bsync[2];
		end
		if (l_r.done) begin
			// Without burst mode, clocks beyond the first word are surplus.
			l_nxt.over = 1'b1;
		end else begin
			l_nxt.sh = {l_r.sh[13:0], sdi_i};
			l_nxt.cnt = l_r.cnt + 4'h1;
			if (l_r.cnt == `MMC_WORD_LAST) begin
				w_nxt.cmd = {l_r.sh, sdi_i};
				w_nxt.tog = ~w_r.tog;
				l_nxt.done = ~l_r.bst;
			end
		end
		l_nxt.mid = l_nxt.over | (l_nxt.cnt != 4'h0);
	end

	always_ff @(posedge sclk_i or posedge cs_b_i) begin
		if (cs_b_i) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	// The word and its toggle survive chip select, but the toggle needs a known start.
	// The serial clock is idle while the system reset is low, so clearing here is safe.
	always_ff @(posedge sclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			w_r <= '0;
		end else begin
			w_r <= w_nxt;
		end
	end

	// Read data leaves on the falling edge; the upper byte is zero.
	always_ff @(negedge sclk_i or posedge cs_b_i) begin
		if (cs_b_i) begin
			sdo_r <= 1'b0;
		end else if (l_r.cnt >= `MMC_RDATA_BIT && !l_r.done) begin
			sdo_r <= s_r.rd[3'(4'hf - l_r.cnt)];
		end else begin
			sdo_r <= 1'b0;
		end
	end

	// System side.
	always_comb begin
		s_nxt = s_r;
		c = mmc_cmd_type'(w_r.cmd);
		chan_nx = next_chan(s_r.chan, s_r.mask);
		s_nxt.trg_s = {s_r.trg_s[1:0], sequence_trigger_pin_i};
		s_nxt.tog_s = {s_r.tog_s[1:0], w_r.tog};
		s_nxt.cs_s = {s_r.cs_s[1:0], cs_b_i};
		s_nxt.mid_s = {s_r.mid_s[1:0], l_r.mid};
		s_nxt.mid_d = {s_r.mid_d[0], s_r.mid_st};
		trg_ev = 1'b0;
		cmd_ev = 1'b0;
		cs_rise = 1'b0;
		if (s_r.trg_s[1] == s_r.trg_s[2]) begin
			s_nxt.trg_st = s_r.trg_s[2];
			// One event per settled transition of the selected polarity.
			trg_ev = (s_r.trg_s[2] != s_r.trg_st) && (s_r.trg_s[2] == s_r.edge_rise);
		end
		if (s_r.tog_s[1] == s_r.tog_s[2]) begin
			s_nxt.tog_st = s_r.tog_s[2];
			cmd_ev = s_r.tog_s[2] != s_r.tog_st;
		end
		if (s_r.cs_s[1] == s_r.cs_s[2]) begin
			s_nxt.cs_st = s_r.cs_s[2];
			cs_rise = s_r.cs_s[2] && !s_r.cs_st;
		end
		if (s_r.mid_s[1] == s_r.mid_s[2]) begin
			s_nxt.mid_st = s_r.mid_s[2];
		end
		// Chip select clears the link side at once, so look back two cycles.
		if (cs_rise) begin
			s_nxt.ferr = s_r.mid_st | s_r.mid_d[0] | s_r.mid_d[1];
		end
		adv = s_r.seq && trg_ev;
		if (adv) begin
			s_nxt.chan = chan_nx;
		end
		wr = cmd_ev && !c.rd;
		key_fire = wr && s_r.armed && c.adr == `MMC_ADR_KEY && c.dat == `MMC_KEY_FIRE;
		if (wr) begin
			// Reserved bits are dropped rather than stored.
			unique case (c.adr)
				`MMC_ADR_BURST: s_nxt.burst = c.dat[`MMC_EN_BIT];
				`MMC_ADR_SEQ:   s_nxt.seq = c.dat[`MMC_EN_BIT];
				`MMC_ADR_MASK:  s_nxt.mask = c.dat & MASK_ALL;
				`MMC_ADR_EDGE:  s_nxt.edge_rise = c.dat[`MMC_EN_BIT];
				default:        s_nxt.burst = s_r.burst;
			endcase
			s_nxt.armed = c.adr == `MMC_ADR_KEY && c.dat == `MMC_KEY_ARM;
			s_nxt.rd = 8'h00;
		end else if (cmd_ev) begin
			case (c.adr)
				`MMC_ADR_BURST: s_nxt.rd = {7'h00, s_r.burst};
				`MMC_ADR_SEQ:   s_nxt.rd = {7'h00, s_r.seq};
				`MMC_ADR_MASK:  s_nxt.rd = s_r.mask;
				`MMC_ADR_EDGE:  s_nxt.rd = {7'h00, s_r.edge_rise};
				default:        s_nxt.rd = 8'h00;
			endcase
		end
		if (key_fire) begin
			s_nxt.burst = `MMC_BURST_RST;
			s_nxt.seq = `MMC_SEQ_RST;
			s_nxt.mask = MASK_RST;
			s_nxt.edge_rise = `MMC_EDGE_RST;
			s_nxt.armed = 1'b0;
			s_nxt.rd = 8'h00;
		end
		if (!rst_b_i) begin
			s_nxt = '0;
			s_nxt.mask = MASK_RST;
			s_nxt.cs_s = 3'h7;
			s_nxt.cs_st = 1'b1;
			// Follow the crossing inputs so release makes no false event.
			s_nxt.trg_s = {s_r.trg_s[1:0], sequence_trigger_pin_i};
			s_nxt.trg_st = s_r.trg_s[2];
			s_nxt.tog_s = {s_r.tog_s[1:0], w_r.tog};
			s_nxt.tog_st = s_r.tog_s[2];
		end
	end

	always_ff @(posedge clk_i) begin
		s_r <= s_nxt;
	end

	assign chan_sel_o = s_r.chan;
	assign burst_en_o = s_r.burst;
	assign seq_en_o = s_r.seq;
	assign frame_err_o = s_r.ferr;
	assign sdo_o = sdo_r;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_reset_defaults: assert property (!$past(rst_b_i) |-> !s_r.burst && !s_r.seq
		&& !s_r.edge_rise && s_r.mask == MASK_RST)
		else $error("register defaults wrong after reset");
	a_burst_write: assert property (wr && c.adr == `MMC_ADR_BURST && !key_fire
		|=> s_r.burst == $past(c.dat[0]))
		else $error("burst enable not written");
	a_seq_write: assert property (wr && c.adr == `MMC_ADR_SEQ && !key_fire
		|=> seq_en_o == $past(c.dat[0]))
		else $error("sequencer enable not written");
	a_chan_step: assert property (adv |=> chan_sel_o == $past(chan_nx)
		&& s_r.mask[chan_sel_o] | ~|s_r.mask)
		else $error("channel did not step to an included channel");
	a_chan_hold: assert property (!s_r.seq |=> $stable(chan_sel_o))
		else $error("channel moved with sequencer off");
	a_mask_rsvd: assert property ((s_r.mask & ~MASK_ALL) == 8'h00)
		else $error("reserved mask bits set");
	a_edge_once: assert property (adv |=> !adv ##1 !adv)
		else $error("one trigger edge stepped twice");
	a_key_reset: assert property (key_fire |=> !burst_en_o && !seq_en_o
		&& !s_r.edge_rise && s_r.mask == MASK_RST && !s_r.armed)
		else $error("key pair did not restore defaults");
	a_key_abort: assert property (wr && s_r.armed && !(c.adr == `MMC_ADR_KEY
		&& c.dat == `MMC_KEY_ARM) |=> !s_r.armed)
		else $error("armed key survived another write");
	a_key_read: assert property (cmd_ev && c.rd && c.adr == `MMC_ADR_KEY
		|=> s_r.rd == 8'h00)
		else $error("key register read nonzero");
	a_frame_check: assert property (cs_rise && s_r.mid_st |=> frame_err_o)
		else $error("partial word not flagged");

	c_burst_on: cover property (wr && c.adr == `MMC_ADR_BURST && c.dat[0]);
	c_seq_step: cover property (adv ##[1:400] adv);
	c_key_fire: cover property (key_fire);
	c_frame_bad: cover property (cs_rise ##1 frame_err_o);

endmodule

/* File: test/mmc_host.sv */
`timescale 1ns/10ps
module mmc_host (
	// Serial link.
	output logic      sclk_o,
	output logic      cs_b_o,
	output logic      sdi_o,
	input  wire logic sdo_i,
	// Conversion trigger.
	output logic      trig_o
);
	initial begin
		sclk_o = 1'b0;
		cs_b_o = 1'b1;
		sdi_o = 1'b0;
		trig_o = 1'b0;
	end

	// The 3 ns offset keeps link edges clear of the system clock edges.
	task automatic open();
		cs_b_o = 1'b0;
		#103;
	endtask

	task automatic close();
		#20 cs_b_o = 1'b1;
		// A released data line must not keep showing its last bit.
		sdi_o = ~sdi_o;
		#203;
	endtask

	task automatic bits(input int n, input logic [15:0] w, output logic [15:0] r);
		r = 16'h0000;
		for (int i = 15; i > 15 - n; i--) begin
			sdi_o = w[i];
			#80 sclk_o = 1'b1;
			r[i] = sdo_i;
			#80 sclk_o = 1'b0;
		end
	endtask

	task automatic frame(input int n, input logic [15:0] w, output logic [15:0] r);
		open();
		bits(n, w, r);
		close();
	endtask

	task automatic edge_to(input logic lvl);
		trig_o = lvl;
		#100;
	endtask
endmodule

/* File: test/mmc_regs_tb.sv */
`timescale 1ns/10ps
module mmc_regs_tb;
	import mmc_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        sclk, cs_b, sdi, sdo, trig, burst, seq, ferr;
	logic [2:0]  chan;
	logic [15:0] r;
	int          n_errors = 0;
	int          n_checks = 0;

	always #5 clk_i = ~clk_i;

	mmc_regs #(.NCH(8)) mmc_regs_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk),
		.cs_b_i(cs_b), .sdi_i(sdi), .sdo_o(sdo), .sequence_trigger_pin_i(trig),
		.chan_sel_o(chan), .burst_en_o(burst), .seq_en_o(seq), .frame_err_o(ferr));
	mmc_host mmc_host_i (.sclk_o(sclk), .cs_b_o(cs_b), .sdi_o(sdi), .sdo_i(sdo),
		.trig_o(trig));

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks = n_checks + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		mmc_host_i.frame(16, {1'b0, a, d}, r);
	endtask

	// The answer of a read arrives in the following word.
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		mmc_host_i.frame(16, {1'b1, a, 8'h00}, r);
		mmc_host_i.frame(16, 16'h8500, r);
		chk("read data", e, r[7:0]);
	endtask

	task automatic step(input logic lvl, input logic [2:0] e);
		mmc_host_i.edge_to(lvl);
		chk("chan_sel_o", {5'h00, e}, {5'h00, chan});
	endtask

	task automatic t_reset();
		chk("outputs", 8'h00, {4'h0, chan, burst | seq | ferr});
		rd(7'h05, 8'h00);
		rd(7'h06, 8'h00);
		rd(7'h07, 8'hff);
		rd(7'h09, 8'h00);
		rd(7'h0b, 8'h00);
	endtask

	task automatic t_burst();
		wr(7'h05, 8'h01);
		rd(7'h05, 8'h01);
		chk("burst_en_o", 8'h01, {7'h00, burst});
		mmc_host_i.open();
		mmc_host_i.bits(16, 16'h0601, r);
		mmc_host_i.bits(16, 16'h070a, r);
		mmc_host_i.close();
		chk("seq_en_o", 8'h01, {7'h00, seq});
		rd(7'h07, 8'h0a);
	endtask

	task automatic t_robin();
		step(1'b1, 3'h0);
		step(1'b0, 3'h1);
		step(1'b1, 3'h1);
		step(1'b0, 3'h3);
		step(1'b1, 3'h3);
		step(1'b0, 3'h1);
		wr(7'h09, 8'h01);
		step(1'b1, 3'h3);
		step(1'b0, 3'h3);
		wr(7'h06, 8'h00);
		step(1'b1, 3'h3);
	endtask

	task automatic t_ferr();
		mmc_host_i.frame(8, 16'h8500, r);
		chk("frame_err_o", 8'h01, {7'h00, ferr});
		mmc_host_i.frame(16, 16'h8500, r);
		chk("frame_err_o", 8'h00, {7'h00, ferr});
	endtask

	task automatic t_key();
		wr(7'h06, 8'h01);
		wr(7'h0b, 8'ha3);
		wr(7'h0b, 8'h11);
		wr(7'h0b, 8'h05);
		chk("burst_en_o", 8'h01, {7'h00, burst});
		wr(7'h0b, 8'ha3);
		wr(7'h0b, 8'h05);
		chk("burst_seq", 8'h00, {6'h00, burst, seq});
		rd(7'h07, 8'hff);
		rd(7'h09, 8'h00);
		rd(7'h0b, 8'h00);
	endtask

	task automatic wrap_up();
		if (n_errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		t_reset();
		t_burst();
		t_robin();
		t_ferr();
		t_key();
		wrap_up();
	end

	// The sequence takes about 95 us; this leaves ample margin.
	initial begin
		#400000;
		n_errors = n_errors + 1;
		wrap_up();
	end
endmodule
